// ===== rac_cfg.svh
// offsets, field positions, reset values and timing counts of the alarm unit
// Contract
// - flag and pin follow a match within 1.46 ms
// - pin stays low until host cancels
// - stop bit blocks all alarm events
// - shared alarm: disable bit7, weekdays or date
// - select bit: zero weekday, one date
// - any set weekday bit accepts that day
// - disabled alarm register is not compared
// - all disabled gives one event per minute
// - match checked only when time advances
// - flag rises on event, sticks until cleared
// - writing zero clears flag, releases pin
// - writing one leaves flag unchanged
// - unused alarms need enable kept zero
// - enable gates pin, zero releases it
`ifndef RAC_CFG_SVH
`define RAC_CFG_SVH
// register indices; byte address is four times the index
`define RAC_IDX_MIN 6'h18
`define RAC_IDX_HOUR 6'h19
`define RAC_IDX_DAY 6'h1a
`define RAC_IDX_EXT 6'h1d
`define RAC_IDX_FLAG 6'h1e
`define RAC_IDX_CTRL 6'h1f
`define RAC_IDX_ISTAT 6'h20
`define RAC_IDX_IMASK 6'h21
// field positions
`define RAC_BIT_DIS 7
`define RAC_BIT_WDSEL 3
`define RAC_BIT_AF 3
`define RAC_BIT_STOP 6
`define RAC_BIT_AIE 3
// writable bits of the control register, bits 1..0 read zero
`define RAC_CTRL_WMASK 8'hfc
// reset values
`define RAC_RST_ALARM 8'h00
`define RAC_RST_REG 8'h00
// timing
`define RAC_CLK_PERIOD_NS 10
`define RAC_FLAG_LAT_NS 1460000
`endif

// ===== rac_pkg.sv
// types shared by the alarm interrupt unit
package rac_pkg;
    // current time of day in bcd, weekday one bit per day
    typedef struct packed {
        logic [6:0] minute;
        logic [5:0] hour;
        logic [6:0] weekday;
        logic [5:0] date;
    } rac_time_t;
    // the three alarm registers together
    typedef struct packed {
        logic [7:0] minute;
        logic [7:0] hour;
        logic [7:0] day;
    } rac_alarm_t;
    // bus slave phases
    typedef enum logic [1:0] {
        RAC_BUS_IDLE = 2'b01,
        RAC_BUS_ACC = 2'b10
    } rac_bus_t;
endpackage : rac_pkg

// ===== rac_match.sv
// alarm comparator: current time against the alarm registers
`timescale 1ns/100ps
`include "rac_cfg.svh"
module rac_match
(
    input wire rac_pkg::rac_alarm_t alarm,
    input wire logic date_sel,
    input wire rac_pkg::rac_time_t cur_time,
    output logic hit
);
    // one field: disabled, or equal under the field mask
    function automatic logic field_hit(input logic [7:0] r,
        input logic [6:0] cur, input logic [6:0] msk);
        field_hit = r[`RAC_BIT_DIS] | ((r[6:0] & msk) == (cur & msk));
    endfunction : field_hit

    logic min_ok; // minute field accepts
    logic hour_ok; // hour field accepts
    logic day_ok; // weekday or date field accepts

    // compare all fields; disabled ones always accept
    always_comb
    begin
        min_ok = field_hit(alarm.minute, cur_time.minute, 7'h7f);
        hour_ok = field_hit(alarm.hour, {1'b0, cur_time.hour},
            7'h3f);
        if (date_sel)
        begin
            day_ok = field_hit(alarm.day, {1'b0, cur_time.date},
                7'h3f);
        end
        else
        begin
            // any marked day accepts
            day_ok = alarm.day[`RAC_BIT_DIS] |
                (|(alarm.day[6:0] & cur_time.weekday));
        end
        hit = min_ok & hour_ok & day_ok;
    end
endmodule : rac_match

// ===== rac_irq_ctrl.sv
// sticky event status, mask and level interrupt output
`timescale 1ns/100ps
module rac_irq_ctrl
#(
    parameter int NEVT = 2
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [NEVT-1:0] evt,
    input wire logic wr_status,
    input wire logic wr_mask,
    input wire logic [NEVT-1:0] wdata,
    output logic [NEVT-1:0] status,
    output logic [NEVT-1:0] mask,
    output logic irq
);
    logic [NEVT-1:0] status_reg; // sticky event bits
    logic [NEVT-1:0] mask_reg; // one enables the bit
    logic irq_reg; // registered interrupt level
    logic [NEVT-1:0] status_next; // next sticky value

    // write one clears, a new event in the same cycle wins
    always_comb
    begin
        status_next = status_reg & ~(wr_status ? wdata : '0);
        status_next = status_next | evt;
    end

    // status bits
    always_ff @(posedge core_clk)
    begin
        if (rst)
            status_reg <= '0;
        else
            status_reg <= status_next;
    end

    // mask bits
    always_ff @(posedge core_clk)
    begin
        if (rst)
            mask_reg <= '0;
        else if (wr_mask)
            mask_reg <= wdata;
    end

    // interrupt level
    always_ff @(posedge core_clk)
    begin
        if (rst)
            irq_reg <= 1'b0;
        else
            irq_reg <= |(status_next & mask_reg);
    end

    assign status = status_reg;
    assign mask = mask_reg;
    assign irq = irq_reg;
endmodule : rac_irq_ctrl

// ===== rac_alarm_irq.sv
// alarm interrupt unit with apb register access
//
// Local design decision: the APB register port.
`timescale 1ns/100ps
`include "rac_cfg.svh"
module rac_alarm_irq
#(
    // longest allowed delay from match to flag and pin
    parameter int FLAG_LAT_CYC = `RAC_FLAG_LAT_NS / `RAC_CLK_PERIOD_NS
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rac_pkg::rac_time_t cur_time,
    input wire logic minute_adv,
    output logic interrupt_pin_a_o,
    output logic interrupt_pin_a_oe,
    output logic irq
);
    // ************************************************************
    // address decoding
    // ************************************************************

    // true when the byte address selects register index idx
    function automatic logic addr_hit(input logic [7:0] a,
        input logic [5:0] idx);
        addr_hit = (a[1:0] == 2'b00) && (a[7:2] == idx);
    endfunction : addr_hit

    // true for any mapped register
    function automatic logic addr_known(input logic [7:0] a);
        addr_known = addr_hit(a, `RAC_IDX_MIN) ||
            addr_hit(a, `RAC_IDX_HOUR) || addr_hit(a, `RAC_IDX_DAY) ||
            addr_hit(a, `RAC_IDX_EXT) || addr_hit(a, `RAC_IDX_FLAG) ||
            addr_hit(a, `RAC_IDX_CTRL) || addr_hit(a, `RAC_IDX_ISTAT) ||
            addr_hit(a, `RAC_IDX_IMASK);
    endfunction : addr_known

    // ************************************************************
    // declarations
    // ************************************************************

    rac_pkg::rac_bus_t bus_reg; // slave phase
    logic pready_reg; // answer in access phase
    logic pslverr_reg; // unmapped address answer
    logic [31:0] prdata_reg; // read data
    rac_pkg::rac_alarm_t alarm_reg; // three alarm registers
    logic [7:0] ext_reg; // extension settings
    logic [7:0] ctrl_reg; // control settings
    logic af_reg; // alarm flag
    logic pin_oe_reg; // pin driven low
    logic wr_acc; // write takes effect this edge
    logic alarm_hit; // comparator output
    logic alarm_evt; // alarm event this edge
    logic af_clr; // host writes zero to the flag
    logic af_next; // next flag value
    logic [1:0] istat; // sticky status
    logic [1:0] imask; // interrupt mask
    logic [31:0] rd_mux; // read data selected by address
    logic [$clog2(FLAG_LAT_CYC+1)-1:0] lat_cnt; // cycles since match

    // ************************************************************
    // apb slave
    // ************************************************************

    // a write lands at the access edge that sees pready
    assign wr_acc = psel && penable && pwrite && pready_reg;

    // phase tracker, answer given in the first access cycle
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            bus_reg <= rac_pkg::RAC_BUS_IDLE;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            case (bus_reg)
                rac_pkg::RAC_BUS_IDLE:
                begin
                    // setup cycle seen
                    if (psel && !penable)
                    begin
                        bus_reg <= rac_pkg::RAC_BUS_ACC;
                        pready_reg <= 1'b1;
                        pslverr_reg <= !addr_known(paddr);
                    end
                end
                rac_pkg::RAC_BUS_ACC:
                begin
                    // transfer completes at this edge
                    bus_reg <= rac_pkg::RAC_BUS_IDLE;
                    pready_reg <= 1'b0;
                    pslverr_reg <= 1'b0;
                end
                default:
                begin
                    bus_reg <= rac_pkg::RAC_BUS_IDLE;
                    pready_reg <= 1'b0;
                    pslverr_reg <= 1'b0;
                end
            endcase
        end
    end

    // read multiplexer, unused bits read zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (addr_hit(paddr, `RAC_IDX_MIN))
            rd_mux[7:0] = alarm_reg.minute;
        else if (addr_hit(paddr, `RAC_IDX_HOUR))
            rd_mux[7:0] = alarm_reg.hour;
        else if (addr_hit(paddr, `RAC_IDX_DAY))
            rd_mux[7:0] = alarm_reg.day;
        else if (addr_hit(paddr, `RAC_IDX_EXT))
            rd_mux[7:0] = ext_reg;
        else if (addr_hit(paddr, `RAC_IDX_FLAG))
            rd_mux[`RAC_BIT_AF] = af_reg;
        else if (addr_hit(paddr, `RAC_IDX_CTRL))
            rd_mux[7:0] = ctrl_reg;
        else if (addr_hit(paddr, `RAC_IDX_ISTAT))
            rd_mux[1:0] = istat;
        else if (addr_hit(paddr, `RAC_IDX_IMASK))
            rd_mux[1:0] = imask;
    end

    // read data captured at the setup edge
    always_ff @(posedge core_clk)
    begin
        if (rst)
            prdata_reg <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata_reg <= rd_mux;
    end

    // ************************************************************
    // settings registers
    // ************************************************************

    // alarm registers, also usable as plain storage
    always_ff @(posedge core_clk)
    begin
        if (rst)
            alarm_reg <= {3{`RAC_RST_ALARM}};
        else if (wr_acc && addr_hit(paddr, `RAC_IDX_MIN))
            alarm_reg.minute <= pwdata[7:0];
        else if (wr_acc && addr_hit(paddr, `RAC_IDX_HOUR))
            alarm_reg.hour <= pwdata[7:0];
        else if (wr_acc && addr_hit(paddr, `RAC_IDX_DAY))
            alarm_reg.day <= pwdata[7:0];
    end

    // extension and control registers
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ext_reg <= `RAC_RST_REG;
            ctrl_reg <= `RAC_RST_REG;
        end
        else if (wr_acc && addr_hit(paddr, `RAC_IDX_EXT))
            ext_reg <= pwdata[7:0];
        else if (wr_acc && addr_hit(paddr, `RAC_IDX_CTRL))
            ctrl_reg <= pwdata[7:0] & `RAC_CTRL_WMASK;
    end

    // ************************************************************
    // alarm detection
    // ************************************************************

    // comparator runs on the stored values whatever their use
    rac_match u_match
    (
        .alarm(alarm_reg),
        .date_sel(ext_reg[`RAC_BIT_WDSEL]),
        .cur_time(cur_time),
        .hit(alarm_hit)
    );

    // only a time advance can match, never a register write
    assign alarm_evt = minute_adv && alarm_hit &&
        !ctrl_reg[`RAC_BIT_STOP];

    // host clear of the flag; writing one changes nothing
    assign af_clr = wr_acc && addr_hit(paddr, `RAC_IDX_FLAG) &&
        !pwdata[`RAC_BIT_AF];

    // event wins over a clear in the same cycle
    assign af_next = alarm_evt || (af_reg && !af_clr);

    // alarm flag
    always_ff @(posedge core_clk)
    begin
        if (rst)
            af_reg <= 1'b0;
        else
            af_reg <= af_next;
    end

    // open-drain pin: low while flag and enable, else released
    always_ff @(posedge core_clk)
    begin
        if (rst)
            pin_oe_reg <= 1'b0;
        else
            pin_oe_reg <= af_reg && ctrl_reg[`RAC_BIT_AIE];
    end

    // ************************************************************
    // interrupt status: bit0 alarm event, bit1 flag cleared
    // ************************************************************

    rac_irq_ctrl #(.NEVT(2)) u_irq
    (
        .core_clk(core_clk),
        .rst(rst),
        .evt({af_clr && af_reg, alarm_evt}),
        .wr_status(wr_acc && addr_hit(paddr, `RAC_IDX_ISTAT)),
        .wr_mask(wr_acc && addr_hit(paddr, `RAC_IDX_IMASK)),
        .wdata(pwdata[1:0]),
        .status(istat),
        .mask(imask),
        .irq(irq)
    );

    // outputs
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign interrupt_pin_a_o = 1'b0;
    assign interrupt_pin_a_oe = pin_oe_reg;

    // ************************************************************
    // checks
    // ************************************************************

    // cycles from an enabled event until the pin is low
    always_ff @(posedge core_clk)
    begin
        if (rst || pin_oe_reg || !ctrl_reg[`RAC_BIT_AIE])
            lat_cnt <= '0;
        else if (alarm_evt || lat_cnt != '0)
            lat_cnt <= lat_cnt + 1'b1;
    end

    // event seen with the enable set
    sequence s_evt_on;
        alarm_evt && ctrl_reg[`RAC_BIT_AIE];
    endsequence

    // flag then pin follow
    sequence s_flag_pin;
        af_reg ##1 pin_oe_reg;
    endsequence

    a_flag_pin_follow: assert property (@(posedge core_clk)
        disable iff (rst)
        s_evt_on ##1 ctrl_reg[`RAC_BIT_AIE] |-> s_flag_pin)
        else $error("flag or pin late after alarm event");

    a_lat_budget: assert property (@(posedge core_clk)
        disable iff (rst) lat_cnt < FLAG_LAT_CYC)
        else $error("alarm latency budget exceeded");

    a_pin_no_release: assert property (@(posedge core_clk)
        disable iff (rst)
        $fell(pin_oe_reg) |-> $past(af_clr, 2) ||
            !$past(ctrl_reg[`RAC_BIT_AIE]))
        else $error("pin released while alarm pending");

    a_stop_blocks: assert property (@(posedge core_clk)
        disable iff (rst)
        ctrl_reg[`RAC_BIT_STOP] && !af_reg |=> !af_reg)
        else $error("alarm event while stopped");

    a_all_disabled: assert property (@(posedge core_clk)
        disable iff (rst)
        minute_adv && !ctrl_reg[`RAC_BIT_STOP] &&
        alarm_reg.minute[7] && alarm_reg.hour[7] && alarm_reg.day[7]
        |=> af_reg)
        else $error("no event with all compares disabled");

    a_only_on_adv: assert property (@(posedge core_clk)
        disable iff (rst)
        $rose(af_reg) |-> $past(minute_adv))
        else $error("flag rose without a time advance");

    a_clear_zero: assert property (@(posedge core_clk)
        disable iff (rst)
        af_clr && !alarm_evt |=> !af_reg ##1 !pin_oe_reg)
        else $error("flag clear did not release pin");

    a_write_one: assert property (@(posedge core_clk)
        disable iff (rst)
        wr_acc && addr_hit(paddr, `RAC_IDX_FLAG) &&
        pwdata[`RAC_BIT_AF] && !alarm_evt |=> af_reg == $past(af_reg))
        else $error("writing one changed the flag");

    a_enable_gate: assert property (@(posedge core_clk)
        disable iff (rst)
        !ctrl_reg[`RAC_BIT_AIE] |=> !pin_oe_reg)
        else $error("pin low with enable cleared");

    a_sticky_flag: assert property (@(posedge core_clk)
        disable iff (rst)
        af_reg && !af_clr |=> af_reg)
        else $error("flag dropped without host clear");

    a_pin_drain: assert property (@(posedge core_clk)
        disable iff (rst)
        interrupt_pin_a_oe |-> !interrupt_pin_a_o && $past(af_reg))
        else $error("pin driven without pending flag");
endmodule : rac_alarm_irq

// ===== rac_time_src.sv
// time counter model feeding the alarm unit one minute step at a time
`timescale 1ns/100ps
module rac_time_src
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic step,
    input wire rac_pkg::rac_time_t next_time,
    output rac_pkg::rac_time_t cur_time,
    output logic minute_adv
);
    // ****************************************
    // counter state
    // ****************************************
    rac_pkg::rac_time_t time_reg; // present time of day
    logic adv_reg; // advance pulse
    assign cur_time = time_reg;
    assign minute_adv = adv_reg;
    // new time and its pulse land together, so the compare sees the new
    // value only when the counter advances
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            time_reg <= '0;
            adv_reg <= 1'b0;
        end
        else
        begin
            adv_reg <= step;
            if (step)
                time_reg <= next_time;
        end
    end
endmodule : rac_time_src

// ===== rtc_alarm_interrupt_tb_top.sv
// self-checking bench for the alarm interrupt unit
`timescale 1ns/100ps
`include "rac_cfg.svh"
module rtc_alarm_interrupt_tb_top;
    // ****************************************
    // signals
    // ****************************************
    localparam logic [7:0] A_MIN = {`RAC_IDX_MIN, 2'b00};
    localparam logic [7:0] A_HR = {`RAC_IDX_HOUR, 2'b00};
    localparam logic [7:0] A_DAY = {`RAC_IDX_DAY, 2'b00};
    localparam logic [7:0] A_EXT = {`RAC_IDX_EXT, 2'b00};
    localparam logic [7:0] A_FLG = {`RAC_IDX_FLAG, 2'b00};
    localparam logic [7:0] A_CTL = {`RAC_IDX_CTRL, 2'b00};
    localparam logic [7:0] A_IST = {`RAC_IDX_ISTAT, 2'b00};
    localparam logic [7:0] A_IMK = {`RAC_IDX_IMASK, 2'b00};
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic step = 1'b0; // ask the time model to advance
    rac_pkg::rac_time_t next_time = '0;
    rac_pkg::rac_time_t cur_time;
    logic minute_adv;
    logic pin_o;
    logic pin_oe;
    logic irq;
    wire pin_a = pin_oe ? pin_o : 1'b1; // pull-up on the open-drain line
    logic [31:0] rd_data; // data of the last transfer
    logic rd_err; // error of the last transfer
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    always #5 core_clk = ~core_clk;
    // ****************************************
    // instances
    // ****************************************
    rac_alarm_irq #(.FLAG_LAT_CYC(8)) dut
    (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cur_time(cur_time),
        .minute_adv(minute_adv), .interrupt_pin_a_o(pin_o),
        .interrupt_pin_a_oe(pin_oe), .irq(irq)
    );
    rac_time_src tsrc
    (
        .core_clk(core_clk), .rst(rst), .step(step),
        .next_time(next_time), .cur_time(cur_time),
        .minute_adv(minute_adv)
    );
    // ****************************************
    // tasks
    // ****************************************
    // verdict and end of run
    task stop_test;
        $display("errors %0d checks %0d", errors, total_checks);
        if (errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    // compare one value
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer, request held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            chk(32'h1, 32'h0);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // advance to a time, then check flag and pin
    task try(input logic [7:0] mi, input logic [7:0] hr,
        input logic [6:0] wd, input logic [5:0] dt,
        input logic fexp, input logic pexp);
        @(posedge core_clk);
        next_time <= '{minute: mi[6:0], hour: hr[5:0], weekday: wd,
            date: dt};
        step <= 1'b1;
        @(posedge core_clk);
        step <= 1'b0;
        repeat (4) @(posedge core_clk);
        apb(1'b0, A_FLG, 32'h0);
        chk(rd_data, fexp ? 32'h8 : 32'h0);
        chk({31'h0, pin_a}, {31'h0, ~pexp});
    endtask : try
    // cancel flag and interrupt status
    task clr;
        apb(1'b1, A_FLG, 32'h0);
        apb(1'b1, A_IST, 32'h3);
        // let the cleared status reach the interrupt level first
        @(posedge core_clk);
        chk({31'h0, pin_a}, 32'h1);
    endtask : clr
    // ****************************************
    // watchdog
    // ****************************************
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors++;
            stop_test;
        end
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial
    begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        apb(1'b0, A_FLG, 32'h0);
        chk(rd_data, 32'h0);
        apb(1'b0, 8'h90, 32'h0);
        chk({31'h0, rd_err}, 32'h1);
        // program with the enable off first
        apb(1'b1, A_CTL, 32'h0);
        apb(1'b1, A_MIN, 32'h30);
        apb(1'b1, A_HR, 32'h07);
        apb(1'b1, A_DAY, 32'h3e);
        apb(1'b1, A_EXT, 32'h0);
        apb(1'b1, A_IMK, 32'h1);
        apb(1'b1, A_CTL, 32'h8);
        // day not in the set, then alarm equal to present time
        try(8'h30, 8'h07, 7'h01, 6'h01, 1'b0, 1'b0);
        apb(1'b1, A_DAY, 32'h01);
        repeat (6) @(posedge core_clk);
        apb(1'b0, A_FLG, 32'h0);
        chk(rd_data, 32'h0);
        apb(1'b1, A_DAY, 32'h3e);
        // weekday match, sticky flag, write one ignored
        try(8'h30, 8'h07, 7'h02, 6'h01, 1'b1, 1'b1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, A_FLG, 32'h8);
        repeat (5) @(posedge core_clk);
        apb(1'b0, A_FLG, 32'h0);
        chk(rd_data, 32'h8);
        chk({31'h0, pin_a}, 32'h0);
        clr;
        chk({31'h0, irq}, 32'h0);
        try(8'h31, 8'h07, 7'h02, 6'h01, 1'b0, 1'b0);
        try(8'h30, 8'h08, 7'h02, 6'h01, 1'b0, 1'b0);
        // date mode
        apb(1'b1, A_EXT, 32'h8);
        apb(1'b1, A_DAY, 32'h15);
        try(8'h30, 8'h07, 7'h02, 6'h14, 1'b0, 1'b0);
        try(8'h30, 8'h07, 7'h00, 6'h15, 1'b1, 1'b1);
        clr;
        // shared register left out of the compare
        apb(1'b1, A_DAY, 32'h80);
        try(8'h30, 8'h07, 7'h00, 6'h01, 1'b1, 1'b1);
        clr;
        // all disabled: every minute
        apb(1'b1, A_MIN, 32'h80);
        apb(1'b1, A_HR, 32'h80);
        try(8'h12, 8'h03, 7'h04, 6'h02, 1'b1, 1'b1);
        clr;
        try(8'h13, 8'h03, 7'h04, 6'h02, 1'b1, 1'b1);
        clr;
        // stopped clock blocks events
        apb(1'b1, A_CTL, 32'h48);
        try(8'h14, 8'h03, 7'h04, 6'h02, 1'b0, 1'b0);
        // enable off releases pin, flag stays
        apb(1'b1, A_CTL, 32'h8);
        try(8'h15, 8'h03, 7'h04, 6'h02, 1'b1, 1'b1);
        apb(1'b1, A_CTL, 32'h0);
        repeat (3) @(posedge core_clk);
        chk({31'h0, pin_a}, 32'h1);
        apb(1'b0, A_FLG, 32'h0);
        chk(rd_data, 32'h8);
        clr;
        // masked event: status sticks, no irq, pin stays released
        apb(1'b1, A_IMK, 32'h0);
        try(8'h16, 8'h03, 7'h04, 6'h02, 1'b1, 1'b0);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, A_IST, 32'h0);
        chk(rd_data & 32'h1, 32'h1);
        stop_test;
    end
endmodule : rtc_alarm_interrupt_tb_top
